// *** pdac_pkg.sv ***
/*
 * Shared constants and types for the parallel-input converter front end.
 * Assumes a single 125 MHz clock (REF_CLK) and an active-low asynchronous reset.
 */
// How it works
// - Twelve-bit straight binary sample, top bit most significant
// - True output gets code, complement the remainder
// - Word captured and output updated on rising edge
// - One sample per clock, up to 125 MSPS
// - Any duty cycle works; single-edge capture only
// - Power-down high switches both output currents off
// - Power-down input defaults low, device enabled
// - Off within 50 ns, valid 5 us after wake
`default_nettype none

package pdac_pkg;

    // ------------------------------------------------------------
    // Data format
    // ------------------------------------------------------------
    localparam int          SAMPLE_W    = 12;
    localparam int          FIFO_DEPTH  = 8;
    localparam logic [11:0] CODE_ZERO   = 12'h000;
    localparam logic [11:0] CODE_FULL   = 12'hfff;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS  = 8000;
    localparam int OFF_TIME_PS    = 50000;
    localparam int WAKE_TIME_PS   = 5000000;
    // Longest off time rounds down, least wake time rounds up
    localparam int OFF_CYCLES     = (OFF_TIME_PS / CLK_PERIOD_PS) < 1 ? 1 : (OFF_TIME_PS / CLK_PERIOD_PS);
    localparam int WAKE_CYCLES    = (WAKE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WAKE_W         = 14;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef logic [SAMPLE_W-1:0] pdac_code_t;

    typedef struct packed {
        pdac_code_t current_out_true;
        pdac_code_t current_out_complement;
    } pdac_out_s;

    typedef enum logic [1:0] {
        PD_ACTIVE,
        PD_SLEEP,
        PD_WAKE
    } pdac_pwr_e;

endpackage

`default_nettype wire

// *** pdac_fifo.sv ***
/*
 * Flip-flop FIFO with valid/ready on both sides.
 * Assumes one clock and an active-low asynchronous reset; depth is a power of two.
 */
`default_nettype none

module pdac_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    assign in_ready  = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data  = mem_reg[rd_ptr_reg];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (pop)  rd_ptr_reg <= rd_ptr_reg + 1'b1;
            if (push && !pop) count_reg <= count_reg + 1'b1;
            else if (pop && !push) count_reg <= count_reg - 1'b1;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_ent
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) mem_reg[gi] <= '0;
                else if (push && wr_ptr_reg == AW'(gi)) mem_reg[gi] <= in_data;
            end
        end
    endgenerate

endmodule

`default_nettype wire

// *** pdac_top.sv ***
/*
 * Digital front end of a 12-bit current-steering converter: sample capture,
 * split into true/complement codes, and power-down sequencing.
 * Assumes the source drives SAMPLE synchronous to REF_CLK and POWER_DOWN as a
 * synchronous level; the external pin pull-down is modelled by reset coming up in PD_ACTIVE.
 */
`default_nettype none

module pdac_top (
    // Clock and reset
    input  wire logic                 REF_CLK,
    input  wire logic                 RST_N,
    // Sample stream from the source
    input  wire logic                 SAMPLE_VALID,
    output logic                      SAMPLE_READY,
    input  wire pdac_pkg::pdac_code_t SAMPLE,
    // Power-down control
    input  wire logic                 POWER_DOWN,
    // Converter currents, as codes
    output pdac_pkg::pdac_out_s       CURRENT_OUT,
    output logic                      OUTPUT_VALID,
    output logic                      POWERED_DOWN
);
    import pdac_pkg::*;

    // ------------------------------------------------------------
    // Input buffer
    // ------------------------------------------------------------
    logic       fifo_valid;
    pdac_code_t fifo_data;
    wire        drain = 1'b1;  // One word per clock, drained at full rate

    pdac_fifo #(
        .WIDTH (SAMPLE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (REF_CLK),
        .rst_n     (RST_N),
        .in_valid  (SAMPLE_VALID),
        .in_ready  (SAMPLE_READY),
        .in_data   (SAMPLE),
        .out_valid (fifo_valid),
        .out_ready (drain),
        .out_data  (fifo_data)
    );

    // ------------------------------------------------------------
    // Sample latch
    // ------------------------------------------------------------
    pdac_code_t latched_reg;

    // Rising-edge register holds the code; no level-sensitive path
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) latched_reg <= CODE_ZERO;
        else if (fifo_valid) latched_reg <= fifo_data;
    end

    // ------------------------------------------------------------
    // Power-down sequencer
    // ------------------------------------------------------------
    pdac_pwr_e        pwr_reg;
    pdac_pwr_e        pwr_next;
    logic [WAKE_W-1:0] wake_cnt_reg;
    logic [WAKE_W-1:0] wake_cnt_next;

    wire wake_done = (wake_cnt_reg == WAKE_W'(WAKE_CYCLES - 1));

    always_comb begin
        pwr_next      = pwr_reg;
        wake_cnt_next = '0;
        case (pwr_reg)
            PD_ACTIVE: if (POWER_DOWN) pwr_next = PD_SLEEP;
            PD_SLEEP:  if (!POWER_DOWN) pwr_next = PD_WAKE;
            PD_WAKE: begin
                wake_cnt_next = wake_cnt_reg + 1'b1;
                if (POWER_DOWN) pwr_next = PD_SLEEP;
                else if (wake_done) pwr_next = PD_ACTIVE;
            end
            default:   pwr_next = PD_SLEEP;
        endcase
    end

    // Reset comes up enabled, as with the pin left open
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            pwr_reg      <= PD_ACTIVE;
            wake_cnt_reg <= '0;
        end else begin
            pwr_reg      <= pwr_next;
            wake_cnt_reg <= wake_cnt_next;
        end
    end

    // ------------------------------------------------------------
    // Output codes
    // ------------------------------------------------------------
    wire        out_on   = (pwr_next == PD_ACTIVE);
    wire pdac_code_t comp_code = CODE_FULL - latched_reg;
    pdac_out_s  out_reg;
    logic       valid_reg;
    logic       down_reg;

    // Off is zero on both; on resumes the last latched code
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            out_reg   <= '{CODE_ZERO, CODE_FULL};
            valid_reg <= 1'b1;
            down_reg  <= 1'b0;
        end else begin
            out_reg   <= out_on ? pdac_out_s'{latched_reg, comp_code} : pdac_out_s'{CODE_ZERO, CODE_ZERO};
            valid_reg <= out_on;
            down_reg  <= (pwr_next != PD_ACTIVE);
        end
    end

    assign CURRENT_OUT  = out_reg;
    assign OUTPUT_VALID = valid_reg;
    assign POWERED_DOWN = down_reg;

    // ------------------------------------------------------------
    // Check helpers
    // ------------------------------------------------------------
    // Cycles since the pin last stood high while not yet active again
    logic [WAKE_W-1:0] chk_wake_age_reg;
    logic [WAKE_W-1:0] chk_wake_age_next;
    // Cycles the outputs stayed on with the pin high
    logic [3:0]        chk_off_age_reg;
    logic [3:0]        chk_off_age_next;

    wire chk_wake_clear = POWER_DOWN || (pwr_reg == PD_ACTIVE);
    wire chk_wake_full  = (chk_wake_age_reg == '1);
    wire chk_off_count  = POWER_DOWN && OUTPUT_VALID;
    wire chk_off_full   = (chk_off_age_reg == '1);

    // Both ages saturate, so a long sleep cannot wrap them into a pass
    assign chk_wake_age_next = chk_wake_clear ? '0 :
                               chk_wake_full  ? chk_wake_age_reg : chk_wake_age_reg + 1'b1;
    assign chk_off_age_next  = !chk_off_count ? '0 :
                               chk_off_full   ? chk_off_age_reg : chk_off_age_reg + 1'b1;

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            chk_wake_age_reg <= '0;
            chk_off_age_reg  <= '0;
        end else begin
            chk_wake_age_reg <= chk_wake_age_next;
            chk_off_age_reg  <= chk_off_age_next;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    localparam int OFF_MAX = OFF_CYCLES;

    sequence s_pd_rise;
        $rose(POWER_DOWN) && pwr_reg == PD_ACTIVE;
    endsequence

    sequence s_wake_start;
        pwr_reg == PD_SLEEP && !POWER_DOWN;
    endsequence

    sequence s_taken;
        SAMPLE_VALID && SAMPLE_READY;
    endsequence

    // Eight wake cycles in a row with the pin held low
    sequence s_full_wake;
        s_wake_start ##1 (pwr_reg == PD_WAKE && !POWER_DOWN) [*8];
    endsequence

    a_split_full_scale: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        OUTPUT_VALID |-> (CURRENT_OUT.current_out_true + CURRENT_OUT.current_out_complement) == CODE_FULL)
        else $error("true and complement do not sum to full scale");

    a_capture_edge: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        fifo_valid |=> latched_reg == $past(fifo_data))
        else $error("sample not captured on the rising edge");

    a_code_follows: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (pwr_next == PD_ACTIVE) |=> CURRENT_OUT.current_out_true == $past(latched_reg))
        else $error("true output does not track the latched code");

    a_off_fast: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        s_pd_rise |-> ##[1:OFF_MAX] (!OUTPUT_VALID && CURRENT_OUT == '0))
        else $error("output not off within the power-down time");

    a_off_zero: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        POWERED_DOWN |-> CURRENT_OUT == '0)
        else $error("current flows while powered down");

    a_wake_hold: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        s_wake_start |=> !OUTPUT_VALID [*8])
        else $error("output valid too soon after wake");

    a_wake_count: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (pwr_reg == PD_WAKE && wake_done && !POWER_DOWN) |=> pwr_reg == PD_ACTIVE && OUTPUT_VALID)
        else $error("wake delay did not end in active state");

    a_resume_code: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (pwr_reg == PD_WAKE && pwr_next == PD_ACTIVE) |=> CURRENT_OUT.current_out_true == $past(latched_reg))
        else $error("resumed code is not the last latched one");

    a_idle_enabled: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (!POWER_DOWN && pwr_reg == PD_ACTIVE) |=> pwr_reg == PD_ACTIVE)
        else $error("device left enabled state with power-down low");

    // ------------------------------------------------------------
    // Stream path checks
    // ------------------------------------------------------------
    // The buffer never holds more than one word, so each word reaches the latch next cycle
    a_ready_held: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        SAMPLE_READY)
        else $error("buffer refused a word although it drains every cycle");

    a_word_enters: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        s_taken |=> fifo_valid && fifo_data == $past(SAMPLE))
        else $error("accepted word not at the buffer head");

    a_two_cycle_path: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        s_taken ##2 (pwr_next == PD_ACTIVE) |=> CURRENT_OUT.current_out_true == $past(SAMPLE, 3))
        else $error("accepted word not shown two cycles later");

    a_latch_hold: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        !fifo_valid |=> $stable(latched_reg))
        else $error("latched code changed with no word offered");

    a_code_hold: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (OUTPUT_VALID && pwr_next == PD_ACTIVE && $stable(latched_reg)) |=> $stable(CURRENT_OUT))
        else $error("output moved while the latched code held");

    a_full_code: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (OUTPUT_VALID && CURRENT_OUT.current_out_true == CODE_FULL)
            |-> CURRENT_OUT.current_out_complement == CODE_ZERO)
        else $error("complement not empty at full-scale code");

    // ------------------------------------------------------------
    // Power-down checks
    // ------------------------------------------------------------
    a_state_legal: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        pwr_reg inside {PD_ACTIVE, PD_SLEEP, PD_WAKE})
        else $error("power sequencer in an unused state");

    a_flags_apart: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        OUTPUT_VALID != POWERED_DOWN)
        else $error("valid and powered-down flags agree");

    a_pin_forces_off: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        POWER_DOWN |=> POWERED_DOWN && CURRENT_OUT == '0)
        else $error("pin high did not switch the currents off");

    a_comp_off: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        !OUTPUT_VALID |-> CURRENT_OUT.current_out_complement == CODE_ZERO)
        else $error("complement current flows while output is off");

    a_down_entry: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        s_pd_rise |=> pwr_reg == PD_SLEEP && POWERED_DOWN)
        else $error("power-down did not enter the sleep state");

    a_sleep_holds: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (pwr_reg == PD_SLEEP && POWER_DOWN) |=> pwr_reg == PD_SLEEP)
        else $error("sleep left while the pin is high");

    a_idle_pin_low: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (pwr_reg == PD_ACTIVE && !POWER_DOWN) |=> OUTPUT_VALID && !POWERED_DOWN)
        else $error("output not valid with the pin low");

    a_resume_comp: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (pwr_reg == PD_WAKE && pwr_next == PD_ACTIVE)
            |=> CURRENT_OUT.current_out_complement == CODE_FULL - $past(latched_reg))
        else $error("resumed complement is not the remainder of the code");

    // ------------------------------------------------------------
    // Wake and off timing checks
    // ------------------------------------------------------------
    // The pin is sampled low one cycle before the wake count starts
    a_wake_entry: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        s_wake_start |=> pwr_reg == PD_WAKE && wake_cnt_reg == '0)
        else $error("wake count did not start from zero");

    a_wake_steps: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (pwr_reg == PD_WAKE && !POWER_DOWN && !wake_done) |=> wake_cnt_reg == $past(wake_cnt_reg) + 1'b1)
        else $error("wake count skipped or stalled");

    a_wake_abort: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (pwr_reg == PD_WAKE && POWER_DOWN) |=> pwr_reg == PD_SLEEP && !OUTPUT_VALID)
        else $error("pin high during wake did not restart sleep");

    a_wake_early: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        s_full_wake |-> !OUTPUT_VALID && POWERED_DOWN)
        else $error("output valid early in the wake span");

    a_off_bound: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        chk_off_age_reg <= 4'(OFF_CYCLES))
        else $error("outputs stayed on too long after power-down");

    a_wake_bound: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (pwr_reg != PD_ACTIVE && !POWER_DOWN) |-> chk_wake_age_reg <= WAKE_W'(WAKE_CYCLES))
        else $error("wake span ran past its length");

    a_wake_span: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        $rose(OUTPUT_VALID) |-> chk_wake_age_reg == WAKE_W'(WAKE_CYCLES + 1))
        else $error("output became valid at the wrong wake time");

endmodule

`default_nettype wire

// *** pdac_src.sv ***
/*
 * Sample source model that feeds the converter front end.
 * Assumes each call resumes just after a rising edge of clk.
 */
`default_nettype none

module pdac_src (
    // Clock
    input  wire logic            clk,
    // Stream to the front end
    input  wire logic            ready,
    output var logic             valid,
    output pdac_pkg::pdac_code_t sample
);
    timeunit 1ns;
    timeprecision 1ps;
    import pdac_pkg::*;

    // ------------------------------------------------------------
    // Stream driver
    // ------------------------------------------------------------
    initial begin
        valid  = 1'b0;
        sample = CODE_ZERO;
    end

    // Word changes just after the capture edge and holds until taken
    task automatic send(input pdac_code_t w);
        valid  <= 1'b1;
        sample <= w;
        @(posedge clk);
        while (ready !== 1'b1) @(posedge clk);
    endtask

    // A released bus shows the inverse of the last word
    task automatic idle();
        valid  <= 1'b0;
        sample <= ~sample;
    endtask
endmodule

`default_nettype wire

// *** pdac_top_tb.sv ***
/*
 * Self-checking bench for the converter front end.
 * Assumes pdac_top and the pdac_src source model are compiled with it.
 */
`default_nettype none

module pdac_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pdac_pkg::*;

    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    logic       ref_clk;
    logic       rst_n;
    logic       power_down;
    logic       sample_valid;
    logic       sample_ready;
    logic       output_valid;
    logic       powered_down;
    pdac_code_t sample;
    pdac_out_s  current_out;
    int         fail_count;
    int         total_checks;

    pdac_src u_pdac_src (.clk(ref_clk), .ready(sample_ready), .valid(sample_valid), .sample(sample));

    pdac_top u_pdac_top (.REF_CLK(ref_clk), .RST_N(rst_n), .SAMPLE_VALID(sample_valid),
        .SAMPLE_READY(sample_ready), .SAMPLE(sample), .POWER_DOWN(power_down),
        .CURRENT_OUT(current_out), .OUTPUT_VALID(output_valid), .POWERED_DOWN(powered_down));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic pdac_out_s split(input pdac_code_t w);
        return '{w, CODE_FULL - w};
    endfunction

    task automatic measure_wake(output int n);
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
            @(negedge ref_clk);
        end while (output_valid !== 1'b1 && n < 2000);
    endtask

    task automatic complete_run();
        if (fail_count == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_reset();
        @(negedge ref_clk);
        check(current_out, split(CODE_ZERO));
        check(24'({output_valid, powered_down, sample_ready}), 24'h5);
    endtask

    task automatic test_stream();
        pdac_code_t tbl [6] = '{12'h000, 12'hfff, 12'h800, 12'h001, 12'ha5a, 12'h7fe};
        @(posedge ref_clk);
        fork
            begin
                foreach (tbl[i]) u_pdac_src.send(tbl[i]);
                u_pdac_src.idle();
            end
            begin
                repeat (3) @(posedge ref_clk);
                foreach (tbl[i]) begin
                    @(negedge ref_clk);
                    check(current_out, split(tbl[i]));
                    @(posedge ref_clk);
                end
            end
        join
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        check(current_out, split(tbl[5]));
    endtask

    task automatic test_sleep();
        int n;
        @(posedge ref_clk);
        power_down <= 1'b1;
        u_pdac_src.send(12'h3c7);
        u_pdac_src.idle();
        repeat (OFF_CYCLES - 1) @(posedge ref_clk);
        @(negedge ref_clk);
        check(current_out, 24'h0);
        check(24'({output_valid, powered_down}), 24'h1);
        @(posedge ref_clk);
        power_down <= 1'b0;
        measure_wake(n);
        check(24'(n >= WAKE_CYCLES && n <= WAKE_CYCLES + 4), 24'h1);
        check(current_out, split(12'h3c7));
        check(24'(powered_down), 24'h0);
    endtask

    task automatic test_rewake();
        int n;
        @(posedge ref_clk);
        power_down <= 1'b1;
        repeat (8) @(posedge ref_clk);
        power_down <= 1'b0;
        repeat (100) @(posedge ref_clk);
        power_down <= 1'b1;
        repeat (OFF_CYCLES) @(posedge ref_clk);
        @(negedge ref_clk);
        check(24'({output_valid, powered_down}), 24'h1);
        @(posedge ref_clk);
        power_down <= 1'b0;
        measure_wake(n);
        check(24'(n >= WAKE_CYCLES && n <= WAKE_CYCLES + 4), 24'h1);
        check(current_out, split(12'h3c7));
    endtask

    // ------------------------------------------------------------
    // Clock, reset, sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;  // Even duty, the source's preferred clock
    end

    initial begin
        fail_count   = 0;
        total_checks = 0;
        rst_n        = 1'b0;
        power_down   = 1'b0;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        test_reset();
        test_stream();
        test_sleep();
        test_rewake();
        complete_run();
    end

    initial begin
        #80000;
        fail_count++;
        complete_run();
    end
endmodule

`default_nettype wire
